// ### core/mdm_consts.svh
// Constants for the data memory, stack pointer and data pointer block
`ifndef MDM_CONSTS_SVH
`define MDM_CONSTS_SVH
`define MDM_SFR_STACK_PTR 8'h81
`define MDM_SFR_PTR0_LOW 8'h82
`define MDM_SFR_PTR0_HIGH 8'h83
`define MDM_SFR_PTR1_LOW 8'h84
`define MDM_SFR_PTR1_HIGH 8'h85
`define MDM_SFR_PTR_SELECT 8'h86
`define MDM_RST_STACK_PTR 8'h07
`define MDM_RST_PTR_BYTE 8'h00
`define MDM_RST_PTR_SELECT 8'h00
`define MDM_SEL_BIT 0
`define MDM_STEP_EN_BIT 4
`define MDM_TOGGLE_EN_BIT 5
`define MDM_DIR0_BIT 6
`define MDM_DIR1_BIT 7
`define MDM_PSW_BANK_LO 3
`define MDM_PSW_BANK_HI 4
`define MDM_BIT_BYTE_BASE 8'h20
`define MDM_RADIO_REG_LO 16'h0800
`define MDM_RADIO_REG_HI 16'h08ff
`define MDM_TX_FIFO_LO 16'h0900
`define MDM_TX_FIFO_HI 16'h093f
`define MDM_RX_FIFO_LO 16'h0940
`define MDM_RX_FIFO_HI 16'h097f
`define MDM_CYC_ADD_REG 3'h1
`define MDM_CYC_CMP_IMM 3'h4
`define MDM_CYC_PTR_INC 3'h1
`define MDM_CYC_CODE_RD 3'h5
`define MDM_CYC_XDATA_RD 3'h2
`define MDM_CYC_XDATA_WR 3'h1
`define MDM_CYC_PTR_LOAD 3'h3
`define MDM_CYC_PUSH 3'h3
`define MDM_CYC_POP 3'h2
`define MDM_CYC_UNLISTED 3'h0
`endif

// ### core/mdm_pkg.sv
// Types shared by the data memory and pointer block
package mdm_pkg;

    typedef enum logic [3:0] {
        MOP_NONE = 4'h0,
        MOP_DIR_RD = 4'h1,
        MOP_DIR_WR = 4'h2,
        MOP_IND_RD = 4'h3,
        MOP_IND_WR = 4'h4,
        MOP_REG_RD = 4'h5,
        MOP_REG_WR = 4'h6,
        MOP_BIT_RD = 4'h7,
        MOP_BIT_WR = 4'h8,
        MOP_PUSH = 4'h9,
        MOP_POP = 4'ha
    } mdm_mem_op_t;

    typedef enum logic [2:0] {
        DOP_NONE = 3'h0,
        DOP_INC = 3'h1,
        DOP_XDATA_RD = 3'h2,
        DOP_XDATA_WR = 3'h3,
        DOP_CODE_RD = 3'h4,
        DOP_LOAD = 3'h5,
        DOP_JUMP = 3'h6
    } mdm_dp_op_t;

    typedef enum logic [1:0] {
        XR_OTHER = 2'h0,
        XR_RADIO_REG = 2'h1,
        XR_TX_FIFO = 2'h2,
        XR_RX_FIFO = 2'h3
    } mdm_xregion_t;

    typedef struct packed {
        mdm_mem_op_t op;
        logic [7:0] addr;
        logic [2:0] reg_idx;
        logic ri_sel;
        logic [7:0] wdata;
        logic wbit;
    } mdm_mem_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
        logic rbit;
    } mdm_mem_rsp_t;

    typedef struct packed {
        logic valid;
        logic wr;
        logic is_bit;
        logic [7:0] addr;
        logic [2:0] bit_pos;
        logic [7:0] wdata;
        logic wbit;
    } mdm_sfr_fwd_t;

    typedef struct packed {
        mdm_dp_op_t op;
        logic [15:0] load_val;
    } mdm_dp_req_t;

    typedef struct packed {
        logic valid;
        logic is_code;
        logic is_wr;
        logic [15:0] addr;
        mdm_xregion_t region;
    } mdm_xacc_t;

endpackage

// ### core/mdm_core.sv
// Internal data RAM, register banks, bit space, stack pointer and dual data pointers
`timescale 1ns/10ps
`default_nettype none
`include "mdm_consts.svh"

module mdm_core
    import mdm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire mdm_mem_req_t i_mem_req,
    input wire logic [7:0] i_psw,
    input wire mdm_dp_req_t i_dp_req,
    input wire logic [7:0] i_opcode,
    output var mdm_mem_rsp_t o_mem_rsp,
    output var mdm_sfr_fwd_t o_sfr_fwd,
    output var mdm_xacc_t o_xacc,
    output logic [15:0] o_active_ptr,
    output logic [2:0] o_op_cycles
);

    // Plain data, so no reset: software must initialise before use
    logic [7:0] ram_q [0:255];
    logic [7:0] sp_q;
    logic [7:0] sp_d;
    logic [15:0] dp0_q;
    logic [15:0] dp0_d;
    logic [15:0] dp1_q;
    logic [15:0] dp1_d;
    logic [7:0] psel_q;
    logic [7:0] psel_d;

    logic [7:0] bank_base;
    logic [7:0] ind_ptr;
    logic [7:0] eff_addr;
    logic [2:0] bit_pos;
    logic is_wr;
    logic is_bit;
    logic is_sfr;
    logic own_hit;
    logic [7:0] own_rd;
    logic [7:0] byte_rd;
    logic [7:0] byte_wr;
    logic ram_we;
    logic own_we;

    logic sel;
    logic dir_dec;
    logic [15:0] act_ptr;
    logic [15:0] act_nxt;
    logic toggle;

    function automatic logic [15:0] step_ptr(input logic [15:0] v, input logic dec);
        step_ptr = dec ? v - 16'h0001 : v + 16'h0001;
    endfunction

    function automatic mdm_xregion_t region_of(input logic [15:0] a);
        if (a >= `MDM_RADIO_REG_LO && a <= `MDM_RADIO_REG_HI) begin
            region_of = XR_RADIO_REG;
        end else if (a >= `MDM_TX_FIFO_LO && a <= `MDM_TX_FIFO_HI) begin
            region_of = XR_TX_FIFO;
        end else if (a >= `MDM_RX_FIFO_LO && a <= `MDM_RX_FIFO_HI) begin
            region_of = XR_RX_FIFO;
        end else begin
            region_of = XR_OTHER;
        end
    endfunction

    function automatic logic [2:0] cycles_of(input logic [7:0] opc);
        if (opc[7:3] == 5'h05) begin
            cycles_of = `MDM_CYC_ADD_REG;
        end else begin
            case (opc)
                8'hb4: cycles_of = `MDM_CYC_CMP_IMM;
                8'ha3: cycles_of = `MDM_CYC_PTR_INC;
                8'h93: cycles_of = `MDM_CYC_CODE_RD;
                8'he0: cycles_of = `MDM_CYC_XDATA_RD;
                8'hf0: cycles_of = `MDM_CYC_XDATA_WR;
                8'h90: cycles_of = `MDM_CYC_PTR_LOAD;
                8'hc0: cycles_of = `MDM_CYC_PUSH;
                8'hd0: cycles_of = `MDM_CYC_POP;
                default: cycles_of = `MDM_CYC_UNLISTED;
            endcase
        end
    endfunction

    // Operand address decode by addressing mode
    always_comb begin
        bank_base = {3'h0, i_psw[`MDM_PSW_BANK_HI], i_psw[`MDM_PSW_BANK_LO], 3'h0};
        ind_ptr = ram_q[bank_base | {7'h00, i_mem_req.ri_sel}];
        bit_pos = i_mem_req.addr[2:0];
        is_wr = 1'b0;
        is_bit = 1'b0;
        is_sfr = 1'b0;
        eff_addr = 8'h00;
        case (i_mem_req.op)
            MOP_DIR_RD, MOP_DIR_WR: begin
                eff_addr = i_mem_req.addr;
                is_sfr = i_mem_req.addr[7];
                is_wr = (i_mem_req.op == MOP_DIR_WR);
            end
            MOP_IND_RD, MOP_IND_WR: begin
                eff_addr = ind_ptr;
                is_wr = (i_mem_req.op == MOP_IND_WR);
            end
            MOP_REG_RD, MOP_REG_WR: begin
                eff_addr = bank_base | {5'h00, i_mem_req.reg_idx};
                is_wr = (i_mem_req.op == MOP_REG_WR);
            end
            MOP_BIT_RD, MOP_BIT_WR: begin
                is_bit = 1'b1;
                is_wr = (i_mem_req.op == MOP_BIT_WR);
                if (i_mem_req.addr[7]) begin
                    eff_addr = {i_mem_req.addr[7:3], 3'h0};
                    is_sfr = 1'b1;
                end else begin
                    eff_addr = `MDM_BIT_BYTE_BASE + {4'h0, i_mem_req.addr[6:3]};
                end
            end
            MOP_PUSH: begin
                eff_addr = sp_q + 8'h01;
                is_wr = 1'b1;
            end
            MOP_POP: begin
                eff_addr = sp_q;
            end
            default: begin
                eff_addr = 8'h00;
            end
        endcase
    end

    // Block-owned SFRs; none sits on a bit-addressable slot
    always_comb begin
        own_hit = 1'b1;
        case (eff_addr)
            `MDM_SFR_STACK_PTR: own_rd = sp_q;
            `MDM_SFR_PTR0_LOW: own_rd = dp0_q[7:0];
            `MDM_SFR_PTR0_HIGH: own_rd = dp0_q[15:8];
            `MDM_SFR_PTR1_LOW: own_rd = dp1_q[7:0];
            `MDM_SFR_PTR1_HIGH: own_rd = dp1_q[15:8];
            `MDM_SFR_PTR_SELECT: own_rd = psel_q;
            default: begin
                own_rd = 8'h00;
                own_hit = 1'b0;
            end
        endcase
        if (is_bit) begin
            own_hit = 1'b0;
        end
        byte_rd = is_sfr ? own_rd : ram_q[eff_addr];
        byte_wr = i_mem_req.wdata;
        if (is_bit) begin
            byte_wr = byte_rd;
            byte_wr[bit_pos] = i_mem_req.wbit;
        end
        ram_we = is_wr && !is_sfr;
        own_we = is_wr && is_sfr && own_hit;
    end

    always_ff @(posedge i_ref_clk) begin
        if (ram_we) begin
            ram_q[eff_addr] <= byte_wr;
        end
    end

    always_comb begin
        sp_d = sp_q;
        if (i_mem_req.op == MOP_PUSH) begin
            sp_d = sp_q + 8'h01;
        end else if (i_mem_req.op == MOP_POP) begin
            sp_d = sp_q - 8'h01;
        end else if (own_we && eff_addr == `MDM_SFR_STACK_PTR) begin
            sp_d = i_mem_req.wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            sp_q <= `MDM_RST_STACK_PTR;
        end else begin
            sp_q <= sp_d;
        end
    end

    // Data pointers: an instruction's pointer op overrides a same-cycle SPECIAL_FUNCTION_SPACE write
    always_comb begin
        dp0_d = dp0_q;
        dp1_d = dp1_q;
        psel_d = psel_q;
        if (own_we) begin
            case (eff_addr)
                `MDM_SFR_PTR0_LOW: dp0_d[7:0] = i_mem_req.wdata;
                `MDM_SFR_PTR0_HIGH: dp0_d[15:8] = i_mem_req.wdata;
                `MDM_SFR_PTR1_LOW: dp1_d[7:0] = i_mem_req.wdata;
                `MDM_SFR_PTR1_HIGH: dp1_d[15:8] = i_mem_req.wdata;
                `MDM_SFR_PTR_SELECT: psel_d = i_mem_req.wdata;
                default: psel_d = psel_q;
            endcase
        end
        sel = psel_q[`MDM_SEL_BIT];
        act_ptr = sel ? dp1_q : dp0_q;
        dir_dec = sel ? psel_q[`MDM_DIR1_BIT] : psel_q[`MDM_DIR0_BIT];
        act_nxt = act_ptr;
        toggle = 1'b0;
        case (i_dp_req.op)
            DOP_INC: begin
                act_nxt = step_ptr(act_ptr, dir_dec);
                toggle = 1'b1;
            end
            DOP_XDATA_RD, DOP_XDATA_WR, DOP_CODE_RD: begin
                if (psel_q[`MDM_STEP_EN_BIT]) begin
                    act_nxt = step_ptr(act_ptr, dir_dec);
                end
                toggle = 1'b1;
            end
            DOP_LOAD: begin
                act_nxt = i_dp_req.load_val;
                toggle = 1'b1;
            end
            default: toggle = 1'b0;
        endcase
        if (i_dp_req.op != DOP_NONE && i_dp_req.op != DOP_JUMP) begin
            if (sel) begin
                dp1_d = act_nxt;
            end else begin
                dp0_d = act_nxt;
            end
        end
        if (toggle && psel_q[`MDM_TOGGLE_EN_BIT]) begin
            psel_d[`MDM_SEL_BIT] = ~sel;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            dp0_q <= {`MDM_RST_PTR_BYTE, `MDM_RST_PTR_BYTE};
            dp1_q <= {`MDM_RST_PTR_BYTE, `MDM_RST_PTR_BYTE};
            psel_q <= `MDM_RST_PTR_SELECT;
            o_active_ptr <= {`MDM_RST_PTR_BYTE, `MDM_RST_PTR_BYTE};
        end else begin
            dp0_q <= dp0_d;
            dp1_q <= dp1_d;
            psel_q <= psel_d;
            o_active_ptr <= psel_d[`MDM_SEL_BIT] ? dp1_d : dp0_d;
        end
    end

    // Answers, one cycle after the request
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_mem_rsp <= '0;
        end else begin
            o_mem_rsp.valid <= (i_mem_req.op != MOP_NONE) && !is_wr;
            o_mem_rsp.rdata <= byte_rd;
            o_mem_rsp.rbit <= byte_rd[bit_pos];
        end
    end

    // Other SFRs live elsewhere; unoccupied ones are the caller's problem
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_sfr_fwd <= '0;
        end else begin
            o_sfr_fwd.valid <= is_sfr && !own_hit;
            o_sfr_fwd.wr <= is_wr;
            o_sfr_fwd.is_bit <= is_bit;
            o_sfr_fwd.addr <= eff_addr;
            o_sfr_fwd.bit_pos <= bit_pos;
            o_sfr_fwd.wdata <= i_mem_req.wdata;
            o_sfr_fwd.wbit <= i_mem_req.wbit;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_xacc <= '0;
        end else begin
            o_xacc.valid <= (i_dp_req.op == DOP_XDATA_RD) || (i_dp_req.op == DOP_XDATA_WR)
                || (i_dp_req.op == DOP_CODE_RD);
            o_xacc.is_code <= (i_dp_req.op == DOP_CODE_RD);
            o_xacc.is_wr <= (i_dp_req.op == DOP_XDATA_WR);
            o_xacc.addr <= act_ptr;
            o_xacc.region <= (i_dp_req.op == DOP_CODE_RD) ? XR_OTHER : region_of(act_ptr);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_op_cycles <= `MDM_CYC_UNLISTED;
        end else begin
            o_op_cycles <= cycles_of(i_opcode);
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    a_push_pre_inc: assert property (
        i_mem_req.op == MOP_PUSH |=> sp_q == $past(sp_q) + 8'h01 && ram_q[sp_q] == $past(i_mem_req.wdata))
        else $error("push did not pre-increment and store");
    a_pop_post_dec: assert property (
        i_mem_req.op == MOP_POP |=> sp_q == $past(sp_q) - 8'h01 && o_mem_rsp.rdata == ram_q[sp_q + 8'h01])
        else $error("pop did not read then decrement");
    a_upper_ind_ram: assert property (
        (i_mem_req.op == MOP_IND_WR || i_mem_req.op == MOP_PUSH) |=> !o_sfr_fwd.valid)
        else $error("indirect or stack access reached SPECIAL_FUNCTION_SPACE space");
    a_direct_sfr_fwd: assert property (
        i_mem_req.op == MOP_DIR_RD && i_mem_req.addr == 8'h90 |=> o_sfr_fwd.valid && o_sfr_fwd.addr == 8'h90)
        else $error("direct high access not forwarded to SPECIAL_FUNCTION_SPACE space");
    a_bank_reg_write: assert property (
        i_mem_req.op == MOP_REG_WR |=> ram_q[$past(bank_base) | {5'h00, $past(i_mem_req.reg_idx)}]
            == $past(i_mem_req.wdata))
        else $error("bank register write landed elsewhere");
    a_bit_area_map: assert property (
        i_mem_req.op == MOP_BIT_WR && !i_mem_req.addr[7]
        |=> ram_q[8'h20 + {4'h0, $past(i_mem_req.addr[6:3])}][$past(bit_pos)] == $past(i_mem_req.wbit))
        else $error("bit write missed its byte");
    a_sel_toggle: assert property (
        i_dp_req.op == DOP_INC && psel_q[`MDM_TOGGLE_EN_BIT] && !own_we
        |=> psel_q[`MDM_SEL_BIT] != $past(psel_q[`MDM_SEL_BIT]))
        else $error("select bit did not toggle");
    a_sel_hold: assert property (
        i_dp_req.op != DOP_NONE && !psel_q[`MDM_TOGGLE_EN_BIT] && !own_we
        |=> $stable(psel_q[`MDM_SEL_BIT]))
        else $error("select bit changed with toggle disabled");
    a_ptr0_step: assert property (
        i_dp_req.op == DOP_INC && !sel |=> dp0_q == step_ptr($past(dp0_q), $past(psel_q[`MDM_DIR0_BIT])))
        else $error("pointer zero stepped the wrong way");
    a_auto_step: assert property (
        i_dp_req.op == DOP_XDATA_RD && !psel_q[`MDM_STEP_EN_BIT] && sel |=> $stable(dp1_q))
        else $error("pointer stepped with auto-step off");
    a_cycle_table: assert property (
        i_opcode[7:3] == 5'h05 |=> o_op_cycles == 3'h1)
        else $error("add-register cycle count wrong");
    a_cycle_cmp: assert property (
        i_opcode == 8'hb4 |=> o_op_cycles == 3'h4)
        else $error("compare-immediate cycle count wrong");
    a_radio_region: assert property (
        i_dp_req.op == DOP_XDATA_WR && act_ptr[15:8] == 8'h08 |=> o_xacc.region == XR_RADIO_REG)
        else $error("radio register region not flagged");

    c_push_twice: cover property (i_mem_req.op == MOP_PUSH ##2 i_mem_req.op == MOP_PUSH);
    c_toggle_xdata: cover property (psel_q[`MDM_TOGGLE_EN_BIT] && i_dp_req.op == DOP_XDATA_RD);
    c_upper_ind: cover property (i_mem_req.op == MOP_IND_RD && ind_ptr[7]);
    c_rx_fifo: cover property (o_xacc.valid && o_xacc.region == XR_RX_FIFO);

endmodule
`default_nettype wire

// ### tb/mdm_exec_model.sv
// Execution unit model that issues memory, pointer and opcode requests
`timescale 1ns/10ps
`default_nettype none

module mdm_exec_model
    import mdm_pkg::*;
(
    input wire logic i_ref_clk,
    output var mdm_mem_req_t o_mem_req,
    output logic [7:0] o_psw,
    output var mdm_dp_req_t o_dp_req,
    output logic [7:0] o_opcode
);
    initial begin
        o_mem_req = '0;
        o_psw = 8'h00;
        o_dp_req = '0;
        o_opcode = 8'h00;
    end

    // Only occupied special function addresses are ever requested
    task automatic mem(input mdm_mem_op_t op, input logic [7:0] a, input logic [2:0] r, input logic [7:0] d,
                       input logic b);
        @(negedge i_ref_clk);
        o_mem_req <= '{op, a, r, r[0], d, b};
        @(negedge i_ref_clk);
        // Idle fields flip so a stale value cannot pass
        o_mem_req <= '{MOP_NONE, ~a, ~r, ~r[0], ~d, ~b};
    endtask

    task automatic dp(input mdm_dp_op_t op, input logic [15:0] v);
        @(negedge i_ref_clk);
        o_dp_req <= '{op, v};
        @(negedge i_ref_clk);
        o_dp_req <= '{DOP_NONE, ~v};
    endtask

    task automatic opc(input logic [7:0] c);
        @(negedge i_ref_clk);
        o_opcode <= c;
        @(negedge i_ref_clk);
        o_opcode <= ~c;
    endtask

    task automatic set_psw(input logic [7:0] v);
        @(negedge i_ref_clk);
        o_psw <= v;
    endtask
endmodule

`default_nettype wire

// ### tb/mcu_data_memory_and_pointers_bench.sv
// Self-checking bench for the data memory, stack and pointer block
`timescale 1ns/10ps
`default_nettype none

module mcu_data_memory_and_pointers_bench;
    import mdm_pkg::*;
    logic clk;
    logic rstn;
    mdm_mem_req_t mem_req;
    logic [7:0] program_status_word;
    mdm_dp_req_t dp_req;
    logic [7:0] opcode;
    mdm_mem_rsp_t rsp;
    mdm_sfr_fwd_t fwd;
    mdm_xacc_t xa;
    logic [15:0] act;
    logic [2:0] cyc;
    int errors;
    int num_checks;

    mdm_exec_model exec (.i_ref_clk(clk), .o_mem_req(mem_req), .o_psw(program_status_word), .o_dp_req(dp_req), .o_opcode(opcode));
    mdm_core uut (.i_ref_clk(clk), .i_resetn(rstn), .i_mem_req(mem_req), .i_psw(program_status_word), .i_dp_req(dp_req),
        .i_opcode(opcode), .o_mem_rsp(rsp), .o_sfr_fwd(fwd), .o_xacc(xa), .o_active_ptr(act), .o_op_cycles(cyc));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize;
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        exec.mem(MOP_DIR_WR, a, 3'h0, d, 1'b0);
    endtask

    task automatic rd(input mdm_mem_op_t op, input logic [7:0] a, input logic [2:0] r, input logic [7:0] e);
        exec.mem(op, a, r, 8'h00, 1'b0);
        check("read valid", {15'h0, rsp.valid}, 16'h1);
        check("read data", {8'h00, rsp.rdata}, {8'h00, e});
    endtask

    task automatic fchk(input logic [7:0] a, input logic [2:0] p, input logic [1:0] wb);
        check("fwd valid", {15'h0, fwd.valid}, 16'h1);
        check("fwd addr", {8'h00, fwd.addr}, {8'h00, a});
        check("fwd bitpos", {13'h0, fwd.bit_pos}, {13'h0, p});
        check("fwd wr bit", {14'h0, fwd.wr, fwd.is_bit}, {14'h0, wb});
    endtask

    task automatic xchk(input logic [15:0] a, input mdm_xregion_t g, input logic [1:0] cw, input logic [15:0] na);
        check("xacc valid", {15'h0, xa.valid}, 16'h1);
        check("xacc addr", xa.addr, a);
        check("xacc region", {14'h0, xa.region}, {14'h0, g});
        check("xacc kind", {14'h0, xa.is_code, xa.is_wr}, {14'h0, cw});
        check("active ptr", act, na);
    endtask

    task automatic do_reset;
        @(negedge clk);
        rstn <= 1'b0;
        repeat (3) @(negedge clk);
        rstn <= 1'b1;
    endtask

    task automatic t_reset;
        rd(MOP_DIR_RD, 8'h81, 3'h0, 8'h07);
        for (int a = 8'h82; a <= 8'h86; a++) begin
            rd(MOP_DIR_RD, 8'(a), 3'h0, 8'h00);
        end
        check("no fwd", {15'h0, fwd.valid}, 16'h0);
        check("reset ptr", act, 16'h0000);
    endtask

    task automatic t_banks;
        for (int b = 0; b < 4; b++) begin
            exec.set_psw(8'(b << 3));
            exec.mem(MOP_REG_WR, 8'h00, 3'h7, 8'(8'h40 + b), 1'b0);
            exec.mem(MOP_REG_WR, 8'h00, 3'h1, 8'(8'h30 + b), 1'b0);
            exec.mem(MOP_IND_WR, 8'h00, 3'h1, 8'(8'h60 + b), 1'b0);
            rd(MOP_DIR_RD, 8'(b * 8 + 7), 3'h0, 8'(8'h40 + b));
            rd(MOP_DIR_RD, 8'(8'h30 + b), 3'h0, 8'(8'h60 + b));
        end
        exec.set_psw(8'he7);
        rd(MOP_REG_RD, 8'h00, 3'h7, 8'h40);
        exec.set_psw(8'h00);
    endtask

    task automatic t_upper;
        exec.mem(MOP_REG_WR, 8'h00, 3'h0, 8'h90, 1'b0);
        exec.mem(MOP_IND_WR, 8'h00, 3'h0, 8'h3c, 1'b0);
        exec.mem(MOP_DIR_WR, 8'h90, 3'h0, 8'h77, 1'b0);
        fchk(8'h90, 3'h0, 2'b10);
        check("fwd wdata", {8'h00, fwd.wdata}, 16'h0077);
        rd(MOP_IND_RD, 8'h00, 3'h0, 8'h3c);
        rd(MOP_DIR_RD, 8'h90, 3'h0, 8'h00);
        exec.mem(MOP_REG_WR, 8'h00, 3'h0, 8'hff, 1'b0);
        exec.mem(MOP_IND_WR, 8'h00, 3'h0, 8'hc3, 1'b0);
        rd(MOP_IND_RD, 8'h00, 3'h0, 8'hc3);
    endtask

    task automatic t_bits;
        wr(8'h22, 8'h00);
        wr(8'h13, 8'h5a);
        exec.mem(MOP_BIT_WR, 8'h13, 3'h0, 8'h00, 1'b1);
        rd(MOP_DIR_RD, 8'h22, 3'h0, 8'h08);
        rd(MOP_DIR_RD, 8'h13, 3'h0, 8'h5a);
        wr(8'h2f, 8'h80);
        exec.mem(MOP_BIT_RD, 8'h7f, 3'h0, 8'h00, 1'b0);
        check("bit 7f", {15'h0, rsp.rbit}, 16'h1);
        wr(8'h20, 8'hfe);
        exec.mem(MOP_BIT_RD, 8'h00, 3'h0, 8'h00, 1'b0);
        check("bit 00", {15'h0, rsp.rbit}, 16'h0);
        exec.mem(MOP_BIT_WR, 8'h8b, 3'h0, 8'h00, 1'b1);
        fchk(8'h88, 3'h3, 2'b11);
        check("fwd wbit", {15'h0, fwd.wbit}, 16'h1);
        exec.mem(MOP_BIT_RD, 8'hf7, 3'h0, 8'h00, 1'b0);
        fchk(8'hf0, 3'h7, 2'b01);
    endtask

    task automatic t_stack;
        wr(8'h81, 8'h7f);
        exec.mem(MOP_PUSH, 8'h00, 3'h0, 8'h11, 1'b0);
        check("push fwd", {15'h0, fwd.valid}, 16'h0);
        check("push no rsp", {15'h0, rsp.valid}, 16'h0);
        exec.mem(MOP_PUSH, 8'h00, 3'h0, 8'h22, 1'b0);
        rd(MOP_DIR_RD, 8'h81, 3'h0, 8'h81);
        exec.mem(MOP_REG_WR, 8'h00, 3'h0, 8'h80, 1'b0);
        rd(MOP_IND_RD, 8'h00, 3'h0, 8'h11);
        rd(MOP_POP, 8'h00, 3'h0, 8'h22);
        rd(MOP_POP, 8'h00, 3'h0, 8'h11);
        rd(MOP_DIR_RD, 8'h81, 3'h0, 8'h7f);
    endtask

    task automatic t_ptrs;
        exec.dp(DOP_LOAD, 16'h1234);
        check("load0", act, 16'h1234);
        rd(MOP_DIR_RD, 8'h83, 3'h0, 8'h12);
        wr(8'h86, 8'h01);
        exec.dp(DOP_LOAD, 16'h0900);
        check("load1", act, 16'h0900);
        rd(MOP_DIR_RD, 8'h82, 3'h0, 8'h34);
        wr(8'h86, 8'h91);
        exec.dp(DOP_XDATA_RD, 16'h0000);
        xchk(16'h0900, XR_TX_FIFO, 2'b00, 16'h08ff);
        exec.dp(DOP_XDATA_WR, 16'h0000);
        xchk(16'h08ff, XR_RADIO_REG, 2'b01, 16'h08fe);
        wr(8'h86, 8'h50);
        exec.dp(DOP_CODE_RD, 16'h0000);
        xchk(16'h1234, XR_OTHER, 2'b10, 16'h1233);
        exec.dp(DOP_INC, 16'h0000);
        check("dec0", act, 16'h1232);
        exec.dp(DOP_JUMP, 16'h0000);
        check("jump", {xa.valid, act[14:0]}, 16'h1232);
        wr(8'h86, 8'h00);
        exec.dp(DOP_INC, 16'h0000);
        check("inc0", act, 16'h1233);
        exec.dp(DOP_XDATA_RD, 16'h0000);
        xchk(16'h1233, XR_OTHER, 2'b00, 16'h1233);
    endtask

    task automatic t_toggle;
        wr(8'h86, 8'h20);
        exec.dp(DOP_INC, 16'h0000);
        check("toggle inc", act, 16'h08fe);
        rd(MOP_DIR_RD, 8'h86, 3'h0, 8'h21);
        exec.dp(DOP_XDATA_RD, 16'h0000);
        xchk(16'h08fe, XR_RADIO_REG, 2'b00, 16'h1234);
        exec.dp(DOP_LOAD, 16'h0940);
        check("toggle load", act, 16'h08fe);
        exec.dp(DOP_CODE_RD, 16'h0000);
        xchk(16'h08fe, XR_OTHER, 2'b10, 16'h0940);
    endtask

    task automatic t_regions;
        logic [15:0] ad [8] = '{16'h07ff, 16'h0800, 16'h08ff, 16'h0900, 16'h093f, 16'h0940, 16'h097f, 16'h0980};
        mdm_xregion_t rg [8] = '{XR_OTHER, XR_RADIO_REG, XR_RADIO_REG, XR_TX_FIFO, XR_TX_FIFO, XR_RX_FIFO,
            XR_RX_FIFO, XR_OTHER};
        wr(8'h86, 8'h01);
        for (int i = 0; i < 8; i++) begin
            exec.dp(DOP_LOAD, ad[i]);
            exec.dp(DOP_XDATA_WR, 16'h0000);
            xchk(ad[i], rg[i], 2'b01, ad[i]);
        end
    endtask

    task automatic t_cycles;
        logic [7:0] op [11] = '{8'h28, 8'h2f, 8'hb4, 8'ha3, 8'h93, 8'he0, 8'hf0, 8'h90, 8'hc0, 8'hd0, 8'h00};
        logic [2:0] ex [11] = '{3'h1, 3'h1, 3'h4, 3'h1, 3'h5, 3'h2, 3'h1, 3'h3, 3'h3, 3'h2, 3'h0};
        for (int i = 0; i < 11; i++) begin
            exec.opc(op[i]);
            check("cycles", {13'h0, cyc}, {13'h0, ex[i]});
        end
    endtask

    initial begin
        errors = 0;
        num_checks = 0;
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        rstn <= 1'b1;
        t_reset();
        t_banks();
        t_upper();
        t_bits();
        t_stack();
        t_ptrs();
        t_toggle();
        t_regions();
        t_cycles();
        // Second reset mid-run must restore pointer state
        do_reset();
        t_reset();
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        summarize();
    end
endmodule

`default_nettype wire
